// >>> hw/vf_reset_pkg.sv
package vf_reset_pkg;

  // ****************************************************************
  // Block sizing
  // ****************************************************************
  localparam int unsigned NUM_VF_DEF   = 8;
  localparam int unsigned SCOPE_W      = 32;
  localparam int unsigned NUM_SCOPE    = 8;

  // ****************************************************************
  // Mailbox read word layout
  // ****************************************************************
  localparam int unsigned MBX_PROGRESS_POS = 0;
  localparam int unsigned MBX_DONE_POS     = 1;
  localparam int unsigned MBX_W            = 2;

  // ****************************************************************
  // Reset-scope register slots
  // ****************************************************************
  localparam int unsigned SLOT_SOFT_PIN  = 0;
  localparam int unsigned SLOT_FLASH     = 1;
  localparam int unsigned SLOT_LED       = 2;
  localparam int unsigned SLOT_AUX_DET   = 3;
  localparam int unsigned SLOT_WAKE_CTL  = 4;
  localparam int unsigned SLOT_WAKE_FILT = 5;
  localparam int unsigned SLOT_MPS       = 6;
  localparam int unsigned SLOT_RING_BASE = 7;

  // Slots that take srst and clear pulses; ring base keeps contents
  localparam logic [NUM_SCOPE-1:0] SCOPE_HAS_RESET = 8'h7F;

  // Reset values of all slots
  localparam logic [SCOPE_W-1:0] SOFT_PIN_RST  = 32'h0000_0000;
  localparam logic [SCOPE_W-1:0] FLASH_RST     = 32'h0000_0000;
  localparam logic [SCOPE_W-1:0] LED_RST       = 32'h0000_0000;
  localparam logic [SCOPE_W-1:0] AUX_DET_RST   = 32'h0000_0000;
  localparam logic [SCOPE_W-1:0] WAKE_CTL_RST  = 32'h0000_0000;
  localparam logic [SCOPE_W-1:0] WAKE_FILT_RST = 32'h0000_0000;
  localparam logic [SCOPE_W-1:0] MPS_RST       = 32'h0000_0000;
  localparam logic [SCOPE_W-1:0] RING_BASE_RST = 32'h0000_0000;

  localparam logic [NUM_SCOPE*SCOPE_W-1:0] SCOPE_RST_VALS = {
    RING_BASE_RST, MPS_RST, WAKE_FILT_RST, WAKE_CTL_RST,
    AUX_DET_RST, LED_RST, FLASH_RST, SOFT_PIN_RST
  };

  // Reset flag values of the mailbox and gates
  localparam logic MBX_PROGRESS_RST = 1'b1;
  localparam logic MBX_DONE_RST     = 1'b0;
  localparam logic GATE_RST         = 1'b0;

endpackage : vf_reset_pkg

// >>> hw/scope_reg.sv
`timescale 1ns/10ps

module scope_reg #(
  parameter int unsigned      W         = 32,
  parameter bit               HAS_RESET = 1'b1,
  parameter logic [W-1:0]     RST_VAL   = '0
) (
  input  wire logic           sys_clk,
  input  wire logic           srst,
  input  wire logic           clr,
  input  wire logic           wr_en,
  input  wire logic [W-1:0]   wr_data,
  output logic      [W-1:0]   q
);

  typedef struct packed {
    logic [W-1:0] val;
  } state_s;

  // A slot needs at least one bit to hold anything
  if (W < 1) begin : g_chk_w
    $error("Scope slot width must be at least 1");
  end

  state_s st_r;
  state_s st_nxt;

  // A write lands unless a scope clear hits the same cycle
  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      st_nxt.val = wr_data;
    end
    if (HAS_RESET && clr) begin
      st_nxt.val = RST_VAL;
    end
  end

  // Slots without reset keep whatever was written for as long as power holds
  if (HAS_RESET) begin : g_rst
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        st_r.val <= RST_VAL;
      end else begin
        st_r <= st_nxt;
      end
    end
  end else begin : g_keep
    always_ff @(posedge sys_clk) begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.val;

endmodule : scope_reg

// >>> hw/reset_class.sv
`timescale 1ns/10ps

module reset_class (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic ev_power_good,
  input  wire logic ev_iio,
  input  wire logic ev_d3_d0,
  input  wire logic ev_flr,
  input  wire logic ev_pf_sw,
  input  wire logic aux_ok,
  input  wire logic mng_enabled,
  input  wire logic host_low_power,
  input  wire logic wol_enabled,
  output logic      clr_pg_only,
  output logic      clr_led,
  output logic      clr_aux_det,
  output logic      clr_wake_ctx,
  output logic      clr_data_path,
  output logic      clr_mps,
  output logic      clr_mac_phy,
  output logic      clr_pkt_buf
);

  typedef struct packed {
    logic pg_only;
    logic led;
    logic aux_det;
    logic wake_ctx;
    logic data_path;
    logic mps;
    logic mac_phy;
    logic pkt_buf;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic   any_ev;

  assign any_ev = ev_power_good | ev_iio | ev_d3_d0 | ev_flr | ev_pf_sw;

  // Sort each event into the scopes it reaches; one cycle later as pulses
  always_comb begin
    st_nxt           = '0;
    st_nxt.pg_only   = ev_power_good;
    st_nxt.led       = ev_power_good | ev_pf_sw | ev_d3_d0;
    st_nxt.aux_det   = ev_power_good | ev_iio;
    st_nxt.wake_ctx  = ev_power_good | (any_ev & ~aux_ok);
    st_nxt.data_path = any_ev;
    st_nxt.mps       = ev_power_good | ev_iio | ev_d3_d0 | ev_pf_sw;
    st_nxt.mac_phy   = any_ev & ~mng_enabled & host_low_power
                       & ~wol_enabled;
    st_nxt.pkt_buf   = ev_flr;
  end

  // Pulses only: nothing here holds state past one cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clr_pg_only   = st_r.pg_only;
  assign clr_led       = st_r.led;
  assign clr_aux_det   = st_r.aux_det;
  assign clr_wake_ctx  = st_r.wake_ctx;
  assign clr_data_path = st_r.data_path;
  assign clr_mps       = st_r.mps;
  assign clr_mac_phy   = st_r.mac_phy;
  assign clr_pkt_buf   = st_r.pkt_buf;

endmodule : reset_class

// >>> hw/vf_reset_sync.sv
// Contract
// - Any major reset sets every VF progress flag
// - Config-done clears progress, sets done everywhere
// - Mailbox read returns done, then clears it
// - Closed rx gate blocks pool packet assignment
// - Closed tx gate blocks pool data fetch
// - Descriptor fetch continues until queue full
// - PF reset closes all rx/tx gates
// - VF reset closes only its own gates
// - No aux supply: wake context reset
// - Soft pins and flash: power good only
// - LED config: power good, software reset and D3 to D0
// - Aux detected bit: power good, I/O reset
// - Address, filter, ring registers never reset
// - Wake context and shadows are sticky
// - Wake filter control resets with data path
// - MAC/PHY reset only when fully idle
// - FLR clears tx and rx packet buffers
// - Config sticky bits: power good only
// - Max payload size survives FLR
// - Memories reset with their owning block
// - PF FLR sets done flags unannounced
`timescale 1ns/10ps

module vf_reset_sync #(
  parameter int unsigned NUM_VF = vf_reset_pkg::NUM_VF_DEF,
  parameter int unsigned VF_W   = (NUM_VF > 1) ? $clog2(NUM_VF) : 1
) (
  input  wire logic                                   sys_clk,
  input  wire logic                                   srst,
  // Reset event pulses from the reset sources
  input  wire logic                                   ev_power_good,
  input  wire logic                                   ev_iio,
  input  wire logic                                   ev_d3_d0,
  input  wire logic                                   ev_flr,
  input  wire logic                                   ev_pf_sw,
  input  wire logic [NUM_VF-1:0]                      ev_vf_sw,
  input  wire logic [NUM_VF-1:0]                      vf_level_reset,
  // Extended control register write of the config-done bit
  input  wire logic                                   pf_config_done_bit,
  // Mailbox reads
  input  wire logic                                   mbx_rd_en,
  input  wire logic [VF_W-1:0]                        mbx_rd_vf,
  output logic                                        mbx_rd_valid,
  output logic      [vf_reset_pkg::MBX_W-1:0]         mbx_rd_data,
  output logic      [NUM_VF-1:0]                      reset_in_progress_flag,
  output logic      [NUM_VF-1:0]                      reset_done_flag,
  // Gate registers
  input  wire logic                                   gate_wr_en,
  input  wire logic [NUM_VF-1:0]                      gate_wr_rx,
  input  wire logic [NUM_VF-1:0]                      gate_wr_tx,
  output logic      [NUM_VF-1:0]                      vf_rx_gate,
  output logic      [NUM_VF-1:0]                      vf_tx_gate,
  // Receive pool assignment
  input  wire logic                                   rx_pkt_valid,
  input  wire logic [VF_W-1:0]                        rx_pkt_pool,
  output logic                                        rx_pkt_accept,
  // Transmit data and descriptor fetch
  input  wire logic                                   tx_data_req,
  input  wire logic [VF_W-1:0]                        tx_data_pool,
  output logic                                        tx_data_grant,
  input  wire logic [NUM_VF-1:0]                      desc_queue_full,
  output logic      [NUM_VF-1:0]                      desc_fetch_en,
  // Wake and power context
  input  wire logic                                   aux_supply_present,
  input  wire logic                                   mng_enabled,
  input  wire logic                                   host_low_power,
  input  wire logic                                   wol_enabled,
  // Reset-scope registers
  input  wire logic [vf_reset_pkg::NUM_SCOPE-1:0]     scope_wr_en,
  input  wire logic [vf_reset_pkg::SCOPE_W-1:0]       scope_wr_data,
  output logic      [vf_reset_pkg::NUM_SCOPE*vf_reset_pkg::SCOPE_W-1:0] scope_q,
  // Scope clear pulses toward the rest of the port
  output logic                                        cfg_sticky_clr,
  output logic                                        mac_phy_rst,
  output logic                                        pkt_buf_clr,
  output logic                                        mem_block_clr
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // Pool vectors of the port allow at most 64 VFs
  if (NUM_VF < 1 || NUM_VF > 64) begin : g_chk_vf
    $error("NUM_VF must be 1 to 64");
  end
  if ((1 << VF_W) < NUM_VF) begin : g_chk_w
    $error("VF_W too narrow for NUM_VF");
  end
  // Mailbox word must hold both flags at distinct places
  if (vf_reset_pkg::MBX_PROGRESS_POS >= vf_reset_pkg::MBX_W) begin : g_chk_prog
    $error("Progress bit outside mailbox word");
  end
  if (vf_reset_pkg::MBX_DONE_POS >= vf_reset_pkg::MBX_W) begin : g_chk_done
    $error("Done bit outside mailbox word");
  end
  if (vf_reset_pkg::MBX_DONE_POS == vf_reset_pkg::MBX_PROGRESS_POS) begin : g_chk_pair
    $error("Mailbox flags share one bit");
  end
  // Programmed rings would be lost if their slot took a reset
  if (vf_reset_pkg::SCOPE_HAS_RESET[vf_reset_pkg::SLOT_RING_BASE]) begin : g_chk_ring
    $error("Ring base slot must not reset");
  end
  // The ring base and MPS slots must lie inside the slot vector
  if (vf_reset_pkg::SLOT_RING_BASE >= vf_reset_pkg::NUM_SCOPE ||
      vf_reset_pkg::SLOT_MPS >= vf_reset_pkg::NUM_SCOPE) begin : g_chk_slot
    $error("Scope slot index out of range");
  end
  // Slots narrower than one bit have nothing to keep
  if (vf_reset_pkg::SCOPE_W < 1) begin : g_chk_scope_w
    $error("Scope slots need at least one bit");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [NUM_VF-1:0]              progress;
    logic [NUM_VF-1:0]              done;
    logic [NUM_VF-1:0]              rx_gate;
    logic [NUM_VF-1:0]              tx_gate;
    logic                           rd_valid;
    logic [vf_reset_pkg::MBX_W-1:0] rd_data;
    logic                           aux_meta;
    logic                           aux_sync;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic   major_ev;
  logic   pf_ev;
  logic   clr_pg_only;
  logic   clr_led;
  logic   clr_aux_det;
  logic   clr_wake_ctx;
  logic   clr_data_path;
  logic   clr_mps;
  logic   clr_mac_phy;
  logic   clr_pkt_buf;
  logic [vf_reset_pkg::NUM_SCOPE-1:0] scope_clr;

  // Any event that restarts the whole function and the VF handshake
  assign major_ev = ev_power_good | ev_iio | ev_d3_d0 | ev_flr | ev_pf_sw;
  // PF-wide reset for the gates; same set of events
  assign pf_ev    = major_ev;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Order of assignments sets priority: flag clears first, flag sets last, so a
  // hardware set never loses to a read clear in the same cycle
  always_comb begin
    st_nxt          = st_r;
    st_nxt.rd_valid = 1'b0;
    st_nxt.aux_meta = aux_supply_present;
    st_nxt.aux_sync = st_r.aux_meta;

    // Mailbox read returns both flags and consumes the done flag
    if (mbx_rd_en) begin
      st_nxt.rd_valid = 1'b1;
      st_nxt.rd_data  = '0;
      st_nxt.rd_data[vf_reset_pkg::MBX_PROGRESS_POS] = st_r.progress[mbx_rd_vf];
      st_nxt.rd_data[vf_reset_pkg::MBX_DONE_POS]     = st_r.done[mbx_rd_vf];
      st_nxt.done[mbx_rd_vf] = 1'b0;
    end

    // Config done ends the reset window for every VF
    if (pf_config_done_bit) begin
      st_nxt.progress = '0;
      st_nxt.done     = '1;
    end

    // A new reset reopens the window; wins over config done
    if (major_ev) begin
      st_nxt.progress = '1;
    end
    // PF FLR marks done at once; the VFs get no warning beforehand
    if (ev_flr) begin
      st_nxt.done = '1;
    end

    // Software gate write, then resets override
    if (gate_wr_en) begin
      st_nxt.rx_gate = gate_wr_rx;
      st_nxt.tx_gate = gate_wr_tx;
    end
    st_nxt.rx_gate = st_nxt.rx_gate & ~(ev_vf_sw | vf_level_reset);
    st_nxt.tx_gate = st_nxt.tx_gate & ~(ev_vf_sw | vf_level_reset);
    if (pf_ev) begin
      st_nxt.rx_gate = '0;
      st_nxt.tx_gate = '0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // srst stands for a power good reset of the whole block
  // Scope slots take their own reset inside their own module
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r.progress <= {NUM_VF{vf_reset_pkg::MBX_PROGRESS_RST}};
      st_r.done     <= {NUM_VF{vf_reset_pkg::MBX_DONE_RST}};
      st_r.rx_gate  <= {NUM_VF{vf_reset_pkg::GATE_RST}};
      st_r.tx_gate  <= {NUM_VF{vf_reset_pkg::GATE_RST}};
      st_r.rd_valid <= 1'b0;
      st_r.rd_data  <= '0;
      st_r.aux_meta <= 1'b0;
      st_r.aux_sync <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Traffic gating
  // ****************************************************************
  // Pool assignment and data fetch look at the live gate bits
  // Limitation: a pool index past NUM_VF reads no gate bit, keep pools in range
  assign rx_pkt_accept = rx_pkt_valid & st_r.rx_gate[rx_pkt_pool];
  assign tx_data_grant = tx_data_req & st_r.tx_gate[tx_data_pool];
  // Descriptors keep flowing so the queue is primed when the gate opens
  assign desc_fetch_en = ~desc_queue_full;

  assign vf_rx_gate             = st_r.rx_gate;
  assign vf_tx_gate             = st_r.tx_gate;
  assign reset_in_progress_flag = st_r.progress;
  assign reset_done_flag        = st_r.done;
  assign mbx_rd_valid           = st_r.rd_valid;
  assign mbx_rd_data            = st_r.rd_data;

  // ****************************************************************
  // Reset-scope decode
  // ****************************************************************
  // Aux presence is a pin: only the second sync stage is used here
  reset_class u_class (
    .sys_clk        (sys_clk),
    .srst           (srst),
    .ev_power_good  (ev_power_good),
    .ev_iio         (ev_iio),
    .ev_d3_d0       (ev_d3_d0),
    .ev_flr         (ev_flr),
    .ev_pf_sw       (ev_pf_sw),
    .aux_ok         (st_r.aux_sync),
    .mng_enabled    (mng_enabled),
    .host_low_power (host_low_power),
    .wol_enabled    (wol_enabled),
    .clr_pg_only    (clr_pg_only),
    .clr_led        (clr_led),
    .clr_aux_det    (clr_aux_det),
    .clr_wake_ctx   (clr_wake_ctx),
    .clr_data_path  (clr_data_path),
    .clr_mps        (clr_mps),
    .clr_mac_phy    (clr_mac_phy),
    .clr_pkt_buf    (clr_pkt_buf)
  );

  // Route each scope pulse to the slot it governs
  always_comb begin
    scope_clr                               = '0;
    scope_clr[vf_reset_pkg::SLOT_SOFT_PIN]  = clr_pg_only;
    scope_clr[vf_reset_pkg::SLOT_FLASH]     = clr_pg_only;
    scope_clr[vf_reset_pkg::SLOT_LED]       = clr_led;
    scope_clr[vf_reset_pkg::SLOT_AUX_DET]   = clr_aux_det;
    scope_clr[vf_reset_pkg::SLOT_WAKE_CTL]  = clr_wake_ctx;
    scope_clr[vf_reset_pkg::SLOT_WAKE_FILT] = clr_data_path;
    scope_clr[vf_reset_pkg::SLOT_MPS]       = clr_mps;
    scope_clr[vf_reset_pkg::SLOT_RING_BASE] = 1'b0;
  end

  // ****************************************************************
  // Reset-scope registers
  // ****************************************************************
  for (genvar i = 0; i < vf_reset_pkg::NUM_SCOPE; i++) begin : g_scope
    scope_reg #(
      .W         (vf_reset_pkg::SCOPE_W),
      .HAS_RESET (vf_reset_pkg::SCOPE_HAS_RESET[i]),
      .RST_VAL   (vf_reset_pkg::SCOPE_RST_VALS[i*vf_reset_pkg::SCOPE_W +:
                                               vf_reset_pkg::SCOPE_W])
    ) u_slot (
      .sys_clk (sys_clk),
      .srst    (srst),
      .clr     (scope_clr[i]),
      .wr_en   (scope_wr_en[i]),
      .wr_data (scope_wr_data),
      .q       (scope_q[i*vf_reset_pkg::SCOPE_W +: vf_reset_pkg::SCOPE_W])
    );
  end

  // ****************************************************************
  // Clear pulses toward the port
  // ****************************************************************
  // Owners of on-die memories take the data-path pulse as their clear
  assign cfg_sticky_clr = clr_pg_only;
  assign mac_phy_rst    = clr_mac_phy;
  assign pkt_buf_clr    = clr_pkt_buf;
  assign mem_block_clr  = clr_data_path;

endmodule : vf_reset_sync

// >>> testbench/vf_reset_sync_checker.sv
`timescale 1ns/10ps
module vf_reset_sync_checker #(
  parameter int unsigned NUM_VF = 8,
  parameter int unsigned VF_W   = 3
) (
  input wire logic                           sys_clk,
  input wire logic                           srst,
  input wire logic                           ev_power_good,
  input wire logic                           ev_iio,
  input wire logic                           ev_d3_d0,
  input wire logic                           ev_flr,
  input wire logic                           ev_pf_sw,
  input wire logic [NUM_VF-1:0]              ev_vf_sw,
  input wire logic [NUM_VF-1:0]              vf_level_reset,
  input wire logic                           pf_config_done_bit,
  input wire logic                           mbx_rd_en,
  input wire logic [VF_W-1:0]                mbx_rd_vf,
  input wire logic                           mbx_rd_valid,
  input wire logic [vf_reset_pkg::MBX_W-1:0] mbx_rd_data,
  input wire logic [NUM_VF-1:0]              reset_in_progress_flag,
  input wire logic [NUM_VF-1:0]              reset_done_flag,
  input wire logic [NUM_VF-1:0]              vf_rx_gate,
  input wire logic [NUM_VF-1:0]              vf_tx_gate,
  input wire logic [NUM_VF-1:0]              desc_queue_full,
  input wire logic [NUM_VF-1:0]              desc_fetch_en,
  input wire logic                           pkt_buf_clr,
  input wire logic                           cfg_sticky_clr
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Any PF-wide reset event, and the per-VF reset mask
  wire logic              major = ev_power_good | ev_iio | ev_d3_d0 | ev_flr | ev_pf_sw;
  wire logic [NUM_VF-1:0] vfr   = ev_vf_sw | vf_level_reset;
  // A mailbox read is taken on the edge that sees the enable
  sequence read_taken;
    mbx_rd_en;
  endsequence
  // ****************************************************************
  // Properties
  // ****************************************************************
  rd_valid_a: assert property (read_taken |=> mbx_rd_valid)
    else $error("mailbox read not answered");
  rd_data_a: assert property (read_taken |=> mbx_rd_data ==
    {$past(reset_done_flag[mbx_rd_vf]), $past(reset_in_progress_flag[mbx_rd_vf])})
    else $error("mailbox read word wrong");
  // Set paths win over the read clear, so they are left out
  rd_clear_a: assert property (read_taken and !ev_flr && !pf_config_done_bit
    |=> !reset_done_flag[$past(mbx_rd_vf)]) else $error("done flag not cleared by read");
  major_set_a: assert property (major |=> &reset_in_progress_flag)
    else $error("progress flags not set");
  cfg_done_a: assert property (pf_config_done_bit && !major
    |=> reset_in_progress_flag == '0 && reset_done_flag == '1) else $error("config done");
  flr_done_a: assert property (ev_flr |=> &reset_done_flag)
    else $error("done flags not set by function reset");
  gate_close_a: assert property (major |=> vf_rx_gate == '0 && vf_tx_gate == '0)
    else $error("gates open after PF reset");
  vf_gate_a: assert property (vfr != '0 |=>
    ((vf_rx_gate | vf_tx_gate) & $past(vfr)) == '0)
    else $error("VF gates open after VF reset");
  desc_fetch_a: assert property (desc_fetch_en == ~desc_queue_full)
    else $error("descriptor fetch wrong");
  pkt_buf_a: assert property (ev_flr |=> pkt_buf_clr)
    else $error("packet buffers not cleared");
  sticky_clr_a: assert property (ev_power_good |=> cfg_sticky_clr)
    else $error("sticky clear missing");
endmodule : vf_reset_sync_checker

bind vf_reset_sync vf_reset_sync_checker #(.NUM_VF(NUM_VF), .VF_W(VF_W)) vf_reset_sync_checker_i (.*);

// >>> testbench/vf_reset_sync_tb_top.sv
`timescale 1ns/10ps
module vf_reset_sync_tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic sys_clk = 1'b0, srst = 1'b1, pf_config_done_bit = 1'b0, mbx_rd_en = 1'b0;
  logic gate_wr_en = 1'b0, rx_pkt_valid = 1'b0, tx_data_req = 1'b0, wol_enabled = 1'b0;
  logic aux_supply_present = 1'b1, mng_enabled = 1'b1, host_low_power = 1'b0;
  logic [4:0] ev = 5'h00;
  wire ev_power_good, ev_iio, ev_d3_d0, ev_flr, ev_pf_sw;
  logic [7:0] ev_vf_sw = 8'h00, vf_level_reset = 8'h00, gate_wr_rx = 8'h00;
  logic [7:0] gate_wr_tx = 8'h00, desc_queue_full = 8'h00, scope_wr_en = 8'h00;
  logic [2:0] mbx_rd_vf = 3'h0, rx_pkt_pool = 3'h0, tx_data_pool = 3'h0;
  logic [31:0] scope_wr_data = 32'h0;
  logic mbx_rd_valid, rx_pkt_accept, tx_data_grant, cfg_sticky_clr, mac_phy_rst;
  logic pkt_buf_clr, mem_block_clr;
  logic [1:0] mbx_rd_data;
  logic [7:0] reset_in_progress_flag, reset_done_flag, vf_rx_gate, vf_tx_gate, desc_fetch_en;
  logic [255:0] scope_q;
  int n_errors = 0, tests_run = 0, cyc = 0;
  // Slots cleared by pf_sw, flr, d3_d0, iio, power good (aux present)
  localparam logic [7:0] CLR_MASK [5] = '{8'h64, 8'h20, 8'h64, 8'h68, 8'h7F};

  assign {ev_power_good, ev_iio, ev_d3_d0, ev_flr, ev_pf_sw} = ev;
  vf_reset_sync vf_reset_sync_i (.*);

  initial forever #4 sys_clk = ~sys_clk;
  // Cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic step(int n = 1);
    repeat (n) @(negedge sys_clk);
  endtask : step
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  // Fill every scope slot with a pattern that names the slot
  task automatic fill_scope();
    for (int j = 0; j < 8; j++) begin
      scope_wr_en = 8'h01 << j;
      scope_wr_data = 32'hA5A5_0000 + j;
      step();
    end
    scope_wr_en = 8'h00;
  endtask : fill_scope
  task automatic chk_slots(input logic [7:0] m);
    for (int j = 0; j < 8; j++)
      chk(scope_q[j*32+:32], m[j] ? 32'h0 : 32'hA5A5_0000 + j, "scope slot");
  endtask : chk_slots
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_config();
    chk(reset_in_progress_flag, 8'hFF, "progress after reset");
    chk({vf_rx_gate, vf_tx_gate}, 16'h0, "gates after reset");
    repeat (2) begin
      pf_config_done_bit = 1'b1;
      step();
      pf_config_done_bit = 1'b0;
      chk(reset_in_progress_flag, 8'h00, "progress after done");
      chk(reset_done_flag, 8'hFF, "done after config");
    end
  endtask : t_config
  task automatic t_read();
    mbx_rd_en = 1'b1;
    mbx_rd_vf = 3'h2;
    step();
    chk(mbx_rd_valid, 1'b1, "read valid");
    chk(mbx_rd_data, 2'h2, "first read");
    chk(reset_done_flag, 8'hFB, "other flags kept");
    step();
    mbx_rd_en = 1'b0;
    chk(mbx_rd_data, 2'h0, "second read");
    step();
    chk(mbx_rd_valid, 1'b0, "valid one cycle");
  endtask : t_read
  task automatic t_gates();
    {gate_wr_en, gate_wr_rx, gate_wr_tx} = {1'b1, 8'hA5, 8'h3C};
    step();
    gate_wr_en = 1'b0;
    for (int p = 0; p < 8; p++) begin
      {rx_pkt_valid, tx_data_req, rx_pkt_pool, tx_data_pool} = {2'h3, p[2:0], p[2:0]};
      #1 chk(rx_pkt_accept, gate_wr_rx[p], "rx assign");
      chk(tx_data_grant, gate_wr_tx[p], "tx fetch");
      step();
    end
    {rx_pkt_valid, tx_data_req, desc_queue_full} = {2'h0, 8'h0F};
    #1 chk({rx_pkt_accept, tx_data_grant}, 2'h0, "no request");
    chk(desc_fetch_en, 8'hF0, "descriptor fetch");
    step();
    {vf_level_reset, ev_vf_sw} = {8'h01, 8'h04};
    step();
    {vf_level_reset, ev_vf_sw, desc_queue_full} = 24'h0;
    chk({vf_rx_gate, vf_tx_gate}, 16'hA038, "VF gate clear");
  endtask : t_gates
  task automatic t_pf_events();
    for (int i = 0; i < 5; i++) begin
      {gate_wr_en, gate_wr_rx, gate_wr_tx} = {1'b1, 16'hFFFF};
      fill_scope();
      gate_wr_en = 1'b0;
      ev = 5'h01 << i;
      step();
      ev = 5'h00;
      chk({vf_rx_gate, vf_tx_gate}, 16'h0, "gates after PF reset");
      chk(reset_in_progress_flag, 8'hFF, "progress set");
      if (i == 1) chk(reset_done_flag, 8'hFF, "done after FLR");
      chk({pkt_buf_clr, cfg_sticky_clr}, {i == 1, i == 4}, "clear pulses");
      chk({mem_block_clr, mac_phy_rst}, 2'h2, "block clear");
      step();
      chk_slots(CLR_MASK[i]);
    end
  endtask : t_pf_events
  task automatic t_aux_and_reset();
    {aux_supply_present, mng_enabled, host_low_power} = 3'h1;
    step(3);
    fill_scope();
    ev = 5'h02;
    step();
    ev = 5'h00;
    chk(mac_phy_rst, 1'b1, "MAC PHY reset");
    step();
    chk_slots(8'h30);
    wol_enabled = 1'b1;
    ev = 5'h02;
    step();
    ev = 5'h00;
    wol_enabled = 1'b0;
    chk(mac_phy_rst, 1'b0, "MAC PHY kept with wake on");
    srst = 1'b1;
    step(2);
    srst = 1'b0;
    chk(scope_q[255:224], 32'hA5A5_0007, "ring base kept");
    chk(scope_q[31:0], 32'h0, "soft pins reset");
  endtask : t_aux_and_reset
  // ****************************************************************
  // Sequence and verdict
  // ****************************************************************
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    step(6);
    srst = 1'b0;
    step();
    t_config();
    t_read();
    t_gates();
    t_pf_events();
    t_aux_and_reset();
    report_and_stop();
  end
endmodule : vf_reset_sync_tb_top
